// *** rtl/program_counter_and_pointers.sv ***
// Instruction address counter, pointer pairs and table result register
`timescale 1ns/1ps
`default_nettype none
`include "pcp_consts.svh"
module program_counter_and_pointers (
  input  wire logic         i_core_clk,    // Instruction clock
  input  wire logic         i_rst,         // Synchronous reset, high
  input  wire logic         i_exec,        // One instruction completes
  input  wire pcp_pkg::op_t i_op,          // Decoded operation
  input  wire logic [11:0]  i_target,      // Jump or call destination
  input  wire logic [7:0]   i_imm,         // Immediate operand
  input  wire logic [7:0]   i_addr,        // Direct data address, bank 0
  input  wire logic [2:0]   i_bit_sel,     // Bit number for bit tests
  input  wire logic [7:0]   i_accum,       // Accumulator value
  input  wire logic         i_carry,       // Carry flag for add-with-carry
  input  wire logic [7:0]   i_mem_rdata,   // Data memory operand
  input  wire logic [15:0]  i_rom_word,    // Program word at table address
  output logic      [11:0]  o_fetch_addr,  // Address of next fetch
  output logic      [15:0]  o_ind_one_addr,// Bank and location, first pair
  output logic      [15:0]  o_ind_two_addr,// Bank and location, second pair
  output logic      [11:0]  o_table_addr,  // Program address for lookups
  output logic      [7:0]   o_result_reg,  // Table result register
  output var logic          o_accum_we,    // Accumulator write strobe
  output var logic  [7:0]   o_accum_wdata, // Accumulator write data
  output var logic          o_mem_we,      // External data memory write
  output var logic  [7:0]   o_mem_addr,    // External write address
  output var logic  [7:0]   o_mem_wdata,   // External write data
  output var logic          o_skipped      // Last instruction skipped
);

  logic [11:0] cnt_q;       // Instruction address counter
  logic [11:0] cnt_d;       // Next counter value
  logic [11:0] stepped;     // Counter after step or skip
  logic [7:0]  result_q;    // Table result register
  logic [7:0]  ptr1_low;    // First pair, location half
  logic [7:0]  ptr1_high;   // First pair, bank half
  logic [7:0]  ptr2_low;    // Second pair, location half
  logic [7:0]  ptr2_high;   // Second pair, bank half
  logic        own_hit;     // Address falls on a register held here
  logic [7:0]  own_rdata;   // Value of that register
  logic [7:0]  operand;     // Memory operand seen by the instruction
  logic        skip;        // Skip condition is true
  logic [7:0]  step_val;    // Operand after increment or decrement
  logic        imm_ok;      // Immediate target is a working register
  logic        wr_en;       // Instruction writes the data address
  logic [7:0]  wr_data;     // Value written there
  logic        accum_we_d;  // Next accumulator strobe
  logic [7:0]  accum_wd_d;  // Next accumulator data
  logic        carry_in;    // Carry used by add-with-carry
  logic [8:0]  add_sum;     // Lower byte plus accumulator
  logic [7:0]  sub_diff;    // Lower byte minus accumulator
  logic [3:0]  upper_now;   // Upper part, for checks
  logic        is_table;    // Table lookup in this cycle

  // Register reads at a direct address: held registers answer here
  always_comb begin
    own_hit   = 1'b1;
    own_rdata = `BYTE_RESET;
    if (i_addr == `ADDR_PTR1_LOW) begin
      own_rdata = ptr1_low;
    end else if (i_addr == `ADDR_PTR1_HIGH) begin
      own_rdata = ptr1_high;
    end else if (i_addr == `ADDR_RESULT) begin
      own_rdata = result_q;
    end else if (i_addr == `ADDR_PTR2_LOW) begin
      own_rdata = ptr2_low;
    end else if (i_addr == `ADDR_PTR2_HIGH) begin
      own_rdata = ptr2_high;
    end else if (i_addr == `ADDR_CNT_LOWER) begin
      own_rdata = cnt_q[7:0];
    end else if (i_addr == `ADDR_CNT_UPPER) begin
      own_rdata = {4'h0, cnt_q[11:8]};
    end else begin
      own_hit = 1'b0;
    end
  end

  // Operand comes from here or from external data memory
  assign operand = own_hit ? own_rdata : i_mem_rdata;

  // Immediate writes reach only the working registers
  assign imm_ok = (i_addr >= `ADDR_PTR1_LOW) && (i_addr <= `ADDR_WORK_LAST);

  assign is_table  = i_exec && (i_op == pcp_pkg::OP_TABLE);
  assign upper_now = cnt_q[11:8];

  // Skip condition and stepped operand
  skip_eval u_skip (
    .i_op      (i_op),
    .i_operand (operand),
    .i_imm     (i_imm),
    .i_accum   (i_accum),
    .i_bit_sel (i_bit_sel),
    .o_skip    (skip),
    .o_result  (step_val)
  );

  // Data-address write of the current instruction
  always_comb begin
    wr_en   = 1'b0;
    wr_data = i_accum;
    case (i_op)
      pcp_pkg::OP_STORE_DIRECT: begin
        wr_en = 1'b1;
      end
      pcp_pkg::OP_INC_MEM, pcp_pkg::OP_DEC_MEM: begin
        wr_en   = 1'b1;
        wr_data = step_val;
      end
      pcp_pkg::OP_MOV_IMM_REG: begin
        wr_en   = imm_ok;
        wr_data = i_imm;
      end
      default: begin
        wr_en = 1'b0;
      end
    endcase
    wr_en = wr_en && i_exec;
  end

  // Accumulator write of the current instruction
  always_comb begin
    accum_we_d = i_exec;
    accum_wd_d = i_accum;
    case (i_op)
      pcp_pkg::OP_MOV_IMM_ACCUM: begin
        accum_wd_d = i_imm;
      end
      pcp_pkg::OP_LOAD_DIRECT: begin
        accum_wd_d = operand;
      end
      pcp_pkg::OP_INC_TO_ACCUM, pcp_pkg::OP_DEC_TO_ACCUM: begin
        accum_wd_d = step_val;
      end
      pcp_pkg::OP_TABLE: begin
        accum_wd_d = i_rom_word[7:0];
      end
      default: begin
        accum_we_d = 1'b0;
      end
    endcase
  end

  // Next counter value
  always_comb begin
    carry_in = (i_op == pcp_pkg::OP_ADC_LOWER) && i_carry;
    add_sum  = {1'b0, cnt_q[7:0]} + {1'b0, i_accum} + {8'h00, carry_in};
    sub_diff = cnt_q[7:0] - i_accum;
    stepped  = cnt_q + (skip ? `CNT_SKIP : `CNT_STEP);
    cnt_d    = cnt_q;
    if (i_exec) begin
      case (i_op)
        pcp_pkg::OP_JUMP, pcp_pkg::OP_CALL: begin
          cnt_d = i_target;
        end
        pcp_pkg::OP_ADD_LOWER, pcp_pkg::OP_ADC_LOWER: begin
          cnt_d[7:0] = add_sum[7:0];
          if (add_sum[8]) begin
            cnt_d[11:8] = cnt_q[11:8] + `UPPER_CARRY;
          end
        end
        pcp_pkg::OP_SUB_LOWER: begin
          cnt_d = {cnt_q[11:8], sub_diff};
        end
        default: begin
          if (wr_en && (i_addr == `ADDR_CNT_LOWER)) begin
            cnt_d = {cnt_q[11:8], wr_data};
          end else if (wr_en && (i_addr == `ADDR_CNT_UPPER)) begin
            cnt_d = {wr_data[3:0], stepped[7:0]};
          end else begin
            cnt_d = stepped;
          end
        end
      endcase
    end
  end

  // Counter register, cleared by every reset
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_q <= `CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Table result register, loaded by lookups or by writes
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      result_q <= `BYTE_RESET;
    end else if (is_table) begin
      result_q <= i_rom_word[15:8];
    end else if (wr_en && (i_addr == `ADDR_RESULT)) begin
      result_q <= wr_data;
    end
  end

  // First pointer pair
  pointer_pair #(.W(8)) u_ptr_one (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_we_low   (wr_en && (i_addr == `ADDR_PTR1_LOW)),
    .i_we_high  (wr_en && (i_addr == `ADDR_PTR1_HIGH)),
    .i_wdata    (wr_data),
    .o_low      (ptr1_low),
    .o_high     (ptr1_high)
  );

  // Second pointer pair
  pointer_pair #(.W(8)) u_ptr_two (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_we_low   (wr_en && (i_addr == `ADDR_PTR2_LOW)),
    .i_we_high  (wr_en && (i_addr == `ADDR_PTR2_HIGH)),
    .i_wdata    (wr_data),
    .o_low      (ptr2_low),
    .o_high     (ptr2_high)
  );

  // Address outputs straight from the registers
  assign o_fetch_addr   = cnt_q;
  assign o_ind_one_addr = {ptr1_high, ptr1_low};
  assign o_ind_two_addr = {ptr2_high, ptr2_low};
  assign o_table_addr   = {ptr2_high[3:0], ptr2_low};
  assign o_result_reg   = result_q;

  // Accumulator write port, one cycle after the instruction
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_accum_we    <= 1'b0;
      o_accum_wdata <= `BYTE_RESET;
    end else begin
      o_accum_we    <= accum_we_d;
      o_accum_wdata <= accum_wd_d;
    end
  end

  // External memory write port; held registers never go out
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_mem_we    <= 1'b0;
      o_mem_addr  <= `BYTE_RESET;
      o_mem_wdata <= `BYTE_RESET;
    end else begin
      o_mem_we    <= wr_en && !own_hit;
      o_mem_addr  <= i_addr;
      o_mem_wdata <= wr_data;
    end
  end

  // Skip indicator for the decoder, one pulse per skipped slot
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_skipped <= 1'b0;
    end else begin
      o_skipped <= i_exec && skip;
    end
  end

  // Checks on the counter and register behaviour
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // Lower byte overflows during an add into it
  sequence s_lower_overflow;
    i_exec && add_sum[8] &&
      ((i_op == pcp_pkg::OP_ADD_LOWER) || (i_op == pcp_pkg::OP_ADC_LOWER));
  endsequence

  // Upper part moved up by exactly one
  sequence s_upper_bumped;
    ##1 (upper_now == ($past(upper_now) + `UPPER_CARRY));
  endsequence

  a_reset_clears_cnt: assert property (
    disable iff (1'b0) i_rst |=> (o_fetch_addr == `CNT_RESET))
    else $error("counter not zero after reset");

  a_plain_step_one: assert property (
    (i_exec && (i_op == pcp_pkg::OP_PLAIN)) |=>
      (o_fetch_addr == ($past(o_fetch_addr) + `CNT_STEP)))
    else $error("plain instruction did not step by one");

  a_jump_loads_all: assert property (
    (i_exec && ((i_op == pcp_pkg::OP_JUMP) || (i_op == pcp_pkg::OP_CALL)))
      |=> (o_fetch_addr == $past(i_target)))
    else $error("jump target not loaded");

  a_skip_adds_two: assert property (
    (i_exec && skip && !wr_en) |=>
      (o_skipped && (o_fetch_addr == ($past(o_fetch_addr) + `CNT_SKIP))))
    else $error("true skip did not step by two");

  a_add_carry_up: assert property (
    s_lower_overflow |-> s_upper_bumped)
    else $error("lower overflow did not bump upper part");

  a_sub_keeps_up: assert property (
    (i_exec && (i_op == pcp_pkg::OP_SUB_LOWER)) |=>
      (upper_now == $past(upper_now)))
    else $error("subtract changed upper part");

  a_table_split: assert property (
    is_table |=> (o_result_reg == $past(i_rom_word[15:8])) &&
      o_accum_we && (o_accum_wdata == $past(i_rom_word[7:0])))
    else $error("lookup word not split into result and accumulator");

  a_imm_guarded: assert property (
    (i_exec && (i_op == pcp_pkg::OP_MOV_IMM_REG) && !imm_ok) |=>
      (!o_mem_we && $stable(o_ind_one_addr) && $stable(o_ind_two_addr)))
    else $error("immediate reached a non-working register");

  a_lower_page_jump: assert property (
    (i_exec && (i_op == pcp_pkg::OP_STORE_DIRECT) &&
      (i_addr == `ADDR_CNT_LOWER)) |=>
      (o_fetch_addr[7:0] == $past(i_accum)) &&
      (upper_now == $past(upper_now)))
    else $error("move into lower byte left its page");

  a_pair_two_write: assert property (
    (wr_en && (i_addr == `ADDR_PTR2_LOW)) |=>
      (o_ind_two_addr[7:0] == $past(wr_data)) && !o_mem_we)
    else $error("second pair location not written");

endmodule : program_counter_and_pointers
`default_nettype wire

// *** rtl/pcp_consts.svh ***
// Address map, reset values and step constants of the counter and pointer unit
`ifndef PCP_CONSTS_SVH
`define PCP_CONSTS_SVH
`define ADDR_PTR1_LOW   8'h80
`define ADDR_PTR1_HIGH  8'h81
`define ADDR_RESULT     8'h82
`define ADDR_PTR2_LOW   8'h83
`define ADDR_PTR2_HIGH  8'h84
`define ADDR_WORK_LAST  8'h87
`define ADDR_CNT_LOWER  8'hce
`define ADDR_CNT_UPPER  8'hcf
`define CNT_RESET       12'h000
`define CNT_STEP        12'h001
`define CNT_SKIP        12'h002
`define UPPER_CARRY     4'h1
`define INC_DEC_STEP    8'h01
`define INC_WRAP_FROM   8'hff
`define DEC_SKIP_FROM   8'h01
`define BYTE_RESET      8'h00
`endif

// *** rtl/pcp_pkg.sv ***
// Operation codes passed from the instruction decoder to the counter unit
package pcp_pkg;
  // One code per instruction class that touches the counter or the pointers
  typedef enum logic [4:0] {
    OP_PLAIN         = 5'h00,
    OP_JUMP          = 5'h01,
    OP_CALL          = 5'h02,
    OP_CMP_IMM       = 5'h03,
    OP_CMP_MEM       = 5'h04,
    OP_INC_TO_ACCUM  = 5'h05,
    OP_INC_MEM       = 5'h06,
    OP_DEC_TO_ACCUM  = 5'h07,
    OP_DEC_MEM       = 5'h08,
    OP_BIT_CLR       = 5'h09,
    OP_BIT_SET       = 5'h0a,
    OP_MOV_IMM_ACCUM = 5'h0b,
    OP_MOV_IMM_REG   = 5'h0c,
    OP_LOAD_DIRECT   = 5'h0d,
    OP_STORE_DIRECT  = 5'h0e,
    OP_ADD_LOWER     = 5'h0f,
    OP_ADC_LOWER     = 5'h10,
    OP_SUB_LOWER     = 5'h11,
    OP_TABLE         = 5'h12
  } op_t;
endpackage : pcp_pkg

// *** rtl/skip_eval.sv ***
// Skip condition and stepped operand for the conditional-skip instructions
`timescale 1ns/1ps
`default_nettype none
`include "pcp_consts.svh"
module skip_eval (
  input  wire pcp_pkg::op_t i_op,      // Decoded operation
  input  wire logic [7:0]   i_operand, // Memory operand value
  input  wire logic [7:0]   i_imm,     // Immediate operand
  input  wire logic [7:0]   i_accum,   // Accumulator value
  input  wire logic [2:0]   i_bit_sel, // Number of tested bit
  output logic              o_skip,    // Next instruction is skipped
  output logic [7:0]        o_result   // Operand after inc or dec
);
  // Decide the skip and form the stepped value
  always_comb begin
    o_result = i_operand;
    o_skip   = 1'b0;
    case (i_op)
      pcp_pkg::OP_CMP_IMM: begin
        o_skip = (i_accum == i_imm);
      end
      pcp_pkg::OP_CMP_MEM: begin
        o_skip = (i_accum == i_operand);
      end
      pcp_pkg::OP_INC_TO_ACCUM, pcp_pkg::OP_INC_MEM: begin
        o_result = i_operand + `INC_DEC_STEP;
        o_skip   = (i_operand == `INC_WRAP_FROM);
      end
      pcp_pkg::OP_DEC_TO_ACCUM, pcp_pkg::OP_DEC_MEM: begin
        o_result = i_operand - `INC_DEC_STEP;
        o_skip   = (i_operand == `DEC_SKIP_FROM);
      end
      pcp_pkg::OP_BIT_CLR: begin
        o_skip = !i_operand[i_bit_sel];
      end
      pcp_pkg::OP_BIT_SET: begin
        o_skip = i_operand[i_bit_sel];
      end
      default: begin
        o_skip = 1'b0;
      end
    endcase
  end
endmodule : skip_eval
`default_nettype wire

// *** rtl/pointer_pair.sv ***
// One pair of byte registers forming a bank and location pointer
`timescale 1ns/1ps
`default_nettype none
module pointer_pair #(
  parameter int W = 8 // Width of each half
) (
  input  wire logic         i_core_clk, // Core clock
  input  wire logic         i_rst,      // Synchronous reset
  input  wire logic         i_we_low,   // Write low half
  input  wire logic         i_we_high,  // Write high half
  input  wire logic [W-1:0] i_wdata,    // Write data
  output logic      [W-1:0] o_low,      // Location half
  output logic      [W-1:0] o_high      // Bank half
);
  // Low half, also usable as plain working storage
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_low <= '0;
    end else if (i_we_low) begin
      o_low <= i_wdata;
    end
  end

  // High half, also usable as plain working storage
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_high <= '0;
    end else if (i_we_high) begin
      o_high <= i_wdata;
    end
  end
endmodule : pointer_pair
`default_nettype wire

// *** test/core_side_model.sv ***
// Behavioural accumulator, data memory and program memory around the counter unit
`timescale 1ns/1ps
`default_nettype none
module core_side_model (
  input  wire logic        i_core_clk,    // Instruction clock
  input  wire logic [7:0]  i_addr,        // Direct data address
  input  wire logic [11:0] i_table_addr,  // Lookup address
  input  wire logic        i_accum_we,    // Accumulator write strobe
  input  wire logic [7:0]  i_accum_wdata, // Accumulator write data
  input  wire logic        i_mem_we,      // Memory write strobe
  input  wire logic [7:0]  i_mem_addr,    // Memory write address
  input  wire logic [7:0]  i_mem_wdata,   // Memory write data
  output logic      [7:0]  o_accum,       // Current accumulator
  output logic      [7:0]  o_mem_rdata,   // Memory at direct address
  output logic      [15:0] o_rom_word     // Program word at lookup address
);
  logic [7:0] ram_q [256];     // Bank zero data memory
  logic [7:0] acc_q = 8'h00;   // Committed accumulator

  // Known contents everywhere, so no operand is ever unknown
  initial begin
    for (int k = 0; k < 256; k++) begin
      ram_q[k] = ~8'(k);
    end
  end

  // Accumulator and memory take the unit's write strobes
  always @(posedge i_core_clk) begin
    if (i_accum_we) begin
      acc_q <= i_accum_wdata;
    end
    if (i_mem_we) begin
      ram_q[i_mem_addr] <= i_mem_wdata;
    end
  end

  // The unit's write strobes lag the instruction by one cycle; forward a write
  // still on its way, so a back-to-back instruction sees the value it made
  assign o_accum     = i_accum_we ? i_accum_wdata : acc_q;
  assign o_mem_rdata = (i_mem_we && (i_mem_addr == i_addr)) ? i_mem_wdata : ram_q[i_addr];
  // Program word is a fixed pattern of its own address
  assign o_rom_word  = {i_table_addr[7:0] ^ 8'ha5, i_table_addr[11:4]};
endmodule : core_side_model
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the counter, pointer and table unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic         clk = 1'b0;              // Instruction clock
  logic         rst = 1'b1;              // Synchronous reset
  logic         exec = 1'b0;             // Instruction completes
  pcp_pkg::op_t op = pcp_pkg::OP_PLAIN;  // Operation class
  logic [11:0]  tgt = 12'h000;           // Target; low byte is also the address
  logic [7:0]   imm = 8'h00;             // Immediate operand
  logic [2:0]   bsel = 3'h0;             // Tested bit
  logic         cin = 1'b0;              // Carry in
  logic [7:0]   acc;                     // Model accumulator
  logic [7:0]   mrd;                     // Model memory data
  logic [15:0]  rom;                     // Model program word
  logic [11:0]  fetch;                   // Counter
  logic [11:0]  taddr;                   // Lookup address
  logic [15:0]  ind1;                    // First pointer pair
  logic [15:0]  ind2;                    // Second pointer pair
  logic [7:0]   res;                     // Result register
  logic         awe;                     // Accumulator strobe
  logic [7:0]   awd;                     // Accumulator data
  logic         mwe;                     // Memory strobe
  logic [7:0]   maddr;                   // Memory address
  logic [7:0]   mwd;                     // Memory data
  logic         skd;                     // Skip flag
  logic [11:0]  exp_pc = 12'h000;        // Expected counter
  int           error_cnt = 0;           // Mismatches
  int           tests_run = 0;           // Comparisons
  int           cycles = 0;              // Cycle count for the hang limit

  program_counter_and_pointers u_dut (
    .i_core_clk(clk), .i_rst(rst), .i_exec(exec), .i_op(op), .i_target(tgt), .i_imm(imm),
    .i_addr(tgt[7:0]), .i_bit_sel(bsel), .i_accum(acc), .i_carry(cin), .i_mem_rdata(mrd),
    .i_rom_word(rom), .o_fetch_addr(fetch), .o_ind_one_addr(ind1), .o_ind_two_addr(ind2),
    .o_table_addr(taddr), .o_result_reg(res), .o_accum_we(awe), .o_accum_wdata(awd),
    .o_mem_we(mwe), .o_mem_addr(maddr), .o_mem_wdata(mwd), .o_skipped(skd)
  );

  core_side_model u_model (
    .i_core_clk(clk), .i_addr(tgt[7:0]), .i_table_addr(taddr), .i_accum_we(awe),
    .i_accum_wdata(awd), .i_mem_we(mwe), .i_mem_addr(maddr), .i_mem_wdata(mwd),
    .o_accum(acc), .o_mem_rdata(mrd), .o_rom_word(rom)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // Hang limit, far above the hundred or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      stop_test();
    end
  end

  // Counts and verdict, then the end of the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // Compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  // One instruction, taken at the next edge; exec stays high for back-to-back use
  task automatic go(input logic [11:0] npc, input pcp_pkg::op_t o,
                    input logic [11:0] t = 12'h000, input logic [7:0] i = 8'h00,
                    input logic [2:0] b = 3'h0, input logic c = 1'b0);
    exec = 1'b1;
    op = o;
    tgt = t;
    imm = i;
    bsel = b;
    cin = c;
    @(posedge clk);
    #2;
    exp_pc = npc;
    check(16'(fetch), 16'(npc));
  endtask : go

  // Instruction that simply steps the counter
  task automatic step(input pcp_pkg::op_t o, input logic [11:0] t = 12'h000,
                      input logic [7:0] i = 8'h00);
    go(exp_pc + 12'h1, o, t, i);
  endtask : step

  // Memory 0x30 gets mv, accumulator av, then the skip instruction runs
  task automatic skip_case(input pcp_pkg::op_t o, input logic [7:0] mv, input logic [7:0] av,
                           input logic [7:0] im, input logic [2:0] b, input logic sk);
    logic [7:0] r;
    r = (o == pcp_pkg::OP_INC_TO_ACCUM || o == pcp_pkg::OP_INC_MEM) ? mv + 8'h01 : mv - 8'h01;
    step(pcp_pkg::OP_MOV_IMM_ACCUM, 12'h000, mv);
    step(pcp_pkg::OP_STORE_DIRECT, 12'h030);
    step(pcp_pkg::OP_MOV_IMM_ACCUM, 12'h000, av);
    go(exp_pc + (sk ? 12'h2 : 12'h1), o, 12'h030, im, b);
    check(16'(skd), 16'(sk));
    if (o == pcp_pkg::OP_INC_TO_ACCUM || o == pcp_pkg::OP_DEC_TO_ACCUM) begin
      check({7'h00, awe, awd}, {8'h01, r});
    end
    if (o == pcp_pkg::OP_INC_MEM || o == pcp_pkg::OP_DEC_MEM) begin
      check({mwe, 7'h00, maddr}, 16'h8030);
      check(16'(mwd), 16'(r));
    end
  endtask : skip_case

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    #2;
    rst = 1'b0;
    check(16'(fetch), 16'h0000);
    step(pcp_pkg::OP_PLAIN);
    step(pcp_pkg::OP_PLAIN);
    exec = 1'b0;
    @(posedge clk);
    #2;
    check(16'(fetch), 16'(exp_pc));
    go(12'hffe, pcp_pkg::OP_JUMP, 12'hffe);
    step(pcp_pkg::OP_PLAIN);
    step(pcp_pkg::OP_PLAIN);
    go(12'h5a5, pcp_pkg::OP_CALL, 12'h5a5);
    end_test("counter");
    step(pcp_pkg::OP_MOV_IMM_REG, 12'h080, 8'h21);
    step(pcp_pkg::OP_MOV_IMM_REG, 12'h081, 8'h03);
    step(pcp_pkg::OP_MOV_IMM_REG, 12'h082, 8'h9c);
    step(pcp_pkg::OP_MOV_IMM_REG, 12'h083, 8'h5a);
    step(pcp_pkg::OP_MOV_IMM_REG, 12'h084, 8'h0b);
    check(ind1, 16'h0321);
    check(ind2, 16'h0b5a);
    check(16'(res), 16'h009c);
    check(16'(taddr), 16'h0b5a);
    step(pcp_pkg::OP_MOV_IMM_REG, 12'h020, 8'h77);
    check({7'h00, mwe, res}, 16'h009c);
    step(pcp_pkg::OP_MOV_IMM_ACCUM, 12'h000, 8'h3c);
    check({7'h00, awe, awd}, 16'h013c);
    step(pcp_pkg::OP_TABLE);
    check({res, awd}, 16'hffb5);
    check(16'(awe), 16'h0001);
    end_test("pointers");
    step(pcp_pkg::OP_MOV_IMM_ACCUM, 12'h000, 8'h6e);
    step(pcp_pkg::OP_STORE_DIRECT, 12'h020);
    check({mwe, maddr, mwd[6:0]}, {1'b1, 8'h20, 7'h6e});
    step(pcp_pkg::OP_MOV_IMM_ACCUM, 12'h000, 8'h00);
    step(pcp_pkg::OP_LOAD_DIRECT, 12'h020);
    check({7'h00, awe, awd}, 16'h016e);
    step(pcp_pkg::OP_STORE_DIRECT, 12'h081);
    check(ind1, 16'h6e21);
    check(16'(mwe), 16'h0000);
    end_test("direct");
    skip_case(pcp_pkg::OP_CMP_IMM, 8'h00, 8'h12, 8'h12, 3'h0, 1'b1);
    skip_case(pcp_pkg::OP_CMP_IMM, 8'h00, 8'h12, 8'h13, 3'h0, 1'b0);
    skip_case(pcp_pkg::OP_CMP_MEM, 8'h44, 8'h44, 8'h00, 3'h0, 1'b1);
    skip_case(pcp_pkg::OP_CMP_MEM, 8'h44, 8'h45, 8'h44, 3'h0, 1'b0);
    skip_case(pcp_pkg::OP_INC_TO_ACCUM, 8'hff, 8'h00, 8'h00, 3'h0, 1'b1);
    skip_case(pcp_pkg::OP_INC_TO_ACCUM, 8'hfe, 8'h00, 8'h00, 3'h0, 1'b0);
    skip_case(pcp_pkg::OP_INC_MEM, 8'hff, 8'h00, 8'h00, 3'h0, 1'b1);
    skip_case(pcp_pkg::OP_INC_MEM, 8'h00, 8'hff, 8'h00, 3'h0, 1'b0);
    skip_case(pcp_pkg::OP_DEC_TO_ACCUM, 8'h01, 8'h00, 8'h00, 3'h0, 1'b1);
    skip_case(pcp_pkg::OP_DEC_TO_ACCUM, 8'h00, 8'h01, 8'h00, 3'h0, 1'b0);
    skip_case(pcp_pkg::OP_DEC_MEM, 8'h01, 8'h00, 8'h00, 3'h0, 1'b1);
    skip_case(pcp_pkg::OP_DEC_MEM, 8'h02, 8'h01, 8'h00, 3'h0, 1'b0);
    skip_case(pcp_pkg::OP_BIT_CLR, 8'hf7, 8'h00, 8'h00, 3'h3, 1'b1);
    skip_case(pcp_pkg::OP_BIT_CLR, 8'h08, 8'h00, 8'h00, 3'h3, 1'b0);
    skip_case(pcp_pkg::OP_BIT_SET, 8'h80, 8'h00, 8'h00, 3'h7, 1'b1);
    skip_case(pcp_pkg::OP_BIT_SET, 8'h7f, 8'h80, 8'h00, 3'h7, 1'b0);
    end_test("skips");
    step(pcp_pkg::OP_MOV_IMM_ACCUM, 12'h000, 8'h20);
    go(12'h3f0, pcp_pkg::OP_JUMP, 12'h3f0);
    go(12'h410, pcp_pkg::OP_ADD_LOWER);
    go(12'h431, pcp_pkg::OP_ADC_LOWER, 12'h000, 8'h00, 3'h0, 1'b1);
    go(12'h411, pcp_pkg::OP_SUB_LOWER);
    go(12'h410, pcp_pkg::OP_JUMP, 12'h410);
    go(12'h4f0, pcp_pkg::OP_SUB_LOWER);
    end_test("lower byte arithmetic");
    go(12'h420, pcp_pkg::OP_STORE_DIRECT, 12'h0ce);
    check(16'(mwe), 16'h0000);
    step(pcp_pkg::OP_MOV_IMM_ACCUM, 12'h000, 8'h07);
    go(12'h722, pcp_pkg::OP_STORE_DIRECT, 12'h0cf);
    step(pcp_pkg::OP_LOAD_DIRECT, 12'h0ce);
    check({7'h00, awe, awd}, 16'h0122);
    step(pcp_pkg::OP_LOAD_DIRECT, 12'h0cf);
    check({7'h00, awe, awd}, 16'h0107);
    end_test("counter registers");
    exec = 1'b0;
    rst = 1'b1;
    @(posedge clk);
    #2;
    rst = 1'b0;
    check(16'(fetch), 16'h0000);
    check({14'h0000, awe, mwe}, 16'h0000);
    end_test("second reset");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
